//--- core/fault_code_check.sv
// Decoder that tells whether a code is one of the injectable fault codes
`default_nettype none
module fault_code_check (
  // Code under test
  input wire logic [15:0] i_code,
  // Result
  output logic o_valid
);
  // -------------------------------------------------------------
  // Code table
  // -------------------------------------------------------------
  // accepted code list
  always_comb begin
    unique case (i_code)
      16'h0010, 16'h0011, 16'h0012, 16'h0020, 16'h0021, 16'h0022,
      16'h0030, 16'h0031, 16'h0040, 16'h0052, 16'h0060, 16'h0061,
      16'h0070, 16'h0080, 16'h0081, 16'h0090, 16'h0091, 16'h00b0,
      16'h00b1, 16'h00b2, 16'h00c0, 16'h00c4, 16'h00c5, 16'h00c7,
      16'h00c9, 16'h00d0, 16'h00e6, 16'h00f5: o_valid = 1'b1;
      default: o_valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- core/fault_history.sv
// Fault history store with a temporary overlay for an injected fault
`default_nettype none
module fault_history #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Record a real fault
  input wire logic i_record,
  input wire logic [15:0] i_record_code,
  // Overlay of an injected fault
  input wire logic i_overlay,
  input wire logic [15:0] i_overlay_code,
  // Newest shown entry
  output logic [15:0] o_newest
);
  // -------------------------------------------------------------
  // Storage, survives drive reset like the real history would
  // -------------------------------------------------------------
  logic [15:0] entry [DEPTH];
  logic [15:0] newest;

  // Shift on record; reset does not wipe the stored history
  always_ff @(posedge i_clock) begin
    if (i_record) begin
      entry[0] <= i_record_code;
    end
  end

  // Older entries move down one slot per record
  for (genvar g = 1; g < DEPTH; g++) begin : g_shift
    always_ff @(posedge i_clock) begin
      if (i_record) begin
        entry[g] <= entry[g-1];
      end
    end
  end

  // overlay shows injected code, never stored
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      newest <= 16'h0000;
    end else if (i_overlay) begin
      newest <= i_overlay_code;
    end else if (i_record) begin
      newest <= i_record_code;
    end else begin
      newest <= entry[0];
    end
  end

  assign o_newest = newest;
endmodule
`default_nettype wire

//--- core/fault_preset_defines.svh
// Constants for the fault injection and panel link preset block
`ifndef FAULT_PRESET_DEFINES_SVH
`define FAULT_PRESET_DEFINES_SVH

// -------------------------------------------------------------
// Setting reset and read-back values
// -------------------------------------------------------------
`define NO_ACTION_VALUE 16'h270f
`define LINK_PRESET_CODE 16'h000a
`define MENU_PRESET_CODE 16'h0001
`define EXT_DISPLAY_FULL 16'h0000
`define PANEL_MODE_OFF 16'h0000

// -------------------------------------------------------------
// Parameter selector codes on the write port
// -------------------------------------------------------------
`define SEL_FAULT_INJECT 4'h0
`define SEL_LINK_PRESET 4'h1
`define SEL_MENU_PRESET 4'h2
`define SEL_EXT_DISPLAY 4'h3
`define SEL_OP_MODE 4'h4
`define SEL_LINK_SPEED 4'h5
`define SEL_STOP_BITS 4'h6
`define SEL_PARITY 4'h7
`define SEL_RETRY 4'h8
`define SEL_CHECK_INT 4'h9
`define SEL_WAIT_TIME 4'ha
`define SEL_LINE_END 4'hb
`define SEL_STARTUP 4'hc
`define SEL_PROTOCOL 4'hd

// -------------------------------------------------------------
// Preset values loaded into the panel link parameters
// -------------------------------------------------------------
`define PRE_OP_MODE 16'h0000
`define PRE_LINK_SPEED 16'h00c0
`define PRE_STOP_BITS 16'h000a
`define PRE_PARITY 16'h0001
`define PRE_RETRY 16'h270f
`define PRE_CHECK_INT 16'h270f
`define PRE_WAIT_TIME 16'h0000
`define PRE_LINE_END 16'h0001
`define PRE_STARTUP 16'h0001
`define PRE_PROTOCOL 16'h0000

// -------------------------------------------------------------
// Power-up values of the panel link parameters
// -------------------------------------------------------------
`define INI_OP_MODE 16'h0000
`define INI_LINK_SPEED 16'h00c0
`define INI_STOP_BITS 16'h0001
`define INI_PARITY 16'h0002
`define INI_RETRY 16'h0001
`define INI_CHECK_INT 16'h0000
`define INI_WAIT_TIME 16'h270f
`define INI_LINE_END 16'h0001
`define INI_STARTUP 16'h0000
`define INI_PROTOCOL 16'h0000
`define INI_EXT_DISPLAY 16'h270f

`endif

//--- core/fault_preset_pkg.sv
// Types shared by the fault injection and link preset block
`default_nettype none
package fault_preset_pkg;
  typedef enum logic [1:0] {
    fault_idle,
    fault_real,
    fault_injected
  } fault_state_t;
  typedef logic [15:0] param_word_t;
endpackage
`default_nettype wire

//--- core/fault_preset_unit.sv
// Parameter-driven fault injection and panel link preset for a motor drive
`include "fault_preset_defines.svh"
`default_nettype none

module fault_preset_unit
  import fault_preset_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Parameter write port from panel or communication host
  input wire logic i_param_write,
  input wire logic [3:0] i_param_select,
  input wire logic [15:0] i_param_data,
  // Parameter read port
  input wire logic i_param_read,
  input wire logic [3:0] i_read_select,
  output logic [15:0] o_read_data,
  output logic o_read_valid,
  // Drive fault inputs
  input wire logic i_real_fault,
  input wire logic [15:0] i_real_fault_code,
  input wire logic i_panel_mode,
  // Trip, alarm and retry
  output logic o_trip,
  output logic o_alarm_output,
  output logic o_retry_enable,
  // Status and nonvolatile store
  output logic [15:0] o_newest_fault,
  output logic o_menu_error,
  output logic o_preset_done,
  output logic o_nv_store,
  output logic [3:0] o_nv_select,
  output logic [15:0] o_nv_data,
  // Panel link parameters
  output logic [15:0] o_operation_mode_select,
  output logic [15:0] o_panel_link_speed,
  output logic [15:0] o_panel_link_stop_bits,
  output logic [15:0] o_panel_link_parity,
  output logic [15:0] o_panel_link_retry_count,
  output logic [15:0] o_panel_link_check_interval,
  output logic [15:0] o_panel_link_wait_time,
  output logic [15:0] o_panel_link_line_ending,
  output logic [15:0] o_link_startup_mode,
  output logic [15:0] o_protocol_select,
  output logic [15:0] o_extended_display_select
);
  // -------------------------------------------------------------
  // State record
  // -------------------------------------------------------------
  typedef struct packed {
    fault_state_t fstate;
    logic [15:0] fault_code;
    logic trip;
    logic alarm;
    logic retry;
    logic [15:0] read_data;
    logic read_valid;
    logic menu_error;
    logic preset_done;
    logic nv_store;
    logic [3:0] nv_select;
    logic [15:0] nv_data;
    logic [15:0] op_mode;
    logic [15:0] speed;
    logic [15:0] stop_bits;
    logic [15:0] parity;
    logic [15:0] retry_count;
    logic [15:0] check_int;
    logic [15:0] wait_time;
    logic [15:0] line_end;
    logic [15:0] startup;
    logic [15:0] protocol;
    logic [15:0] ext_display;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;
  logic code_ok;
  logic [15:0] newest_shown;
  logic real_sync1;
  logic real_sync2;
  logic panel_sync1;
  logic panel_sync2;
  logic hist_record;

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  // Fault and mode pins come from outside the clock domain
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      real_sync1 <= 1'b0;
      real_sync2 <= 1'b0;
      panel_sync1 <= 1'b0;
      panel_sync2 <= 1'b0;
    end else begin
      real_sync1 <= i_real_fault;
      real_sync2 <= real_sync1;
      panel_sync1 <= i_panel_mode;
      panel_sync2 <= panel_sync1;
    end
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  fault_code_check u_check (
    .i_code(i_param_data),
    .o_valid(code_ok)
  );

  // real fault recorded only when nothing is latched
  assign hist_record = real_sync2 && (st.fstate == fault_idle);

  fault_history #(
    .DEPTH(4)
  ) u_history (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_record(hist_record),
    .i_record_code(i_real_fault_code),
    .i_overlay(next_st.fstate == fault_injected),
    .i_overlay_code(next_st.fault_code),
    .o_newest(newest_shown)
  );

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.read_valid = 1'b0;
    next_st.menu_error = 1'b0;
    next_st.preset_done = 1'b0;
    next_st.nv_store = 1'b0;

    // Real fault latches only when the drive is healthy
    unique case (st.fstate)
      fault_idle: begin
        if (real_sync2) begin
          next_st.fstate = fault_real;
          next_st.fault_code = i_real_fault_code;
        end
      end
      fault_real: begin
        next_st.fstate = fault_real;
      end
      fault_injected: begin
        next_st.fstate = fault_injected;
      end
    endcase

    if (i_param_write) begin
      unique case (i_param_select)
        `SEL_FAULT_INJECT: begin
          // blocked while a fault is active
          // only with extended display select at 0
          // 9999 fails code_ok, so nothing happens
          if (st.fstate == fault_idle && !real_sync2 &&
              st.ext_display == `EXT_DISPLAY_FULL && code_ok) begin
            next_st.fstate = fault_injected;
            next_st.fault_code = i_param_data;
          end
        end
        `SEL_LINK_PRESET, `SEL_MENU_PRESET: begin
          // menu preset needs panel operation mode
          if (i_param_select == `SEL_MENU_PRESET && !panel_sync2) begin
            next_st.menu_error = 1'b1;
          // code 10 or menu 1 runs the preset
          // menu entry gives the identical load
          // 9999 and other values do nothing
          end else if ((i_param_select == `SEL_LINK_PRESET &&
                        i_param_data == `LINK_PRESET_CODE) ||
                       (i_param_select == `SEL_MENU_PRESET &&
                        i_param_data == `MENU_PRESET_CODE)) begin
            next_st.op_mode = `PRE_OP_MODE;
            next_st.speed = `PRE_LINK_SPEED;
            next_st.stop_bits = `PRE_STOP_BITS;
            next_st.parity = `PRE_PARITY;
            next_st.retry_count = `PRE_RETRY;
            next_st.check_int = `PRE_CHECK_INT;
            next_st.wait_time = `PRE_WAIT_TIME;
            next_st.line_end = `PRE_LINE_END;
            next_st.startup = `PRE_STARTUP;
            next_st.protocol = `PRE_PROTOCOL;
            next_st.preset_done = 1'b1;
          end
        end
        `SEL_EXT_DISPLAY: next_st.ext_display = i_param_data;
        `SEL_OP_MODE: next_st.op_mode = i_param_data;
        `SEL_LINK_SPEED: next_st.speed = i_param_data;
        `SEL_STOP_BITS: next_st.stop_bits = i_param_data;
        `SEL_PARITY: next_st.parity = i_param_data;
        `SEL_RETRY: next_st.retry_count = i_param_data;
        `SEL_CHECK_INT: next_st.check_int = i_param_data;
        `SEL_WAIT_TIME: next_st.wait_time = i_param_data;
        `SEL_LINE_END: next_st.line_end = i_param_data;
        `SEL_STARTUP: next_st.startup = i_param_data;
        `SEL_PROTOCOL: next_st.protocol = i_param_data;
        default: ;
      endcase
      if (i_param_select != `SEL_FAULT_INJECT &&
          i_param_select != `SEL_LINK_PRESET &&
          i_param_select != `SEL_MENU_PRESET &&
          i_param_select <= `SEL_PROTOCOL) begin
        next_st.nv_store = 1'b1;
        next_st.nv_select = i_param_select;
        next_st.nv_data = i_param_data;
      end
    end

    // any latched fault trips and raises the alarm
    next_st.trip = (next_st.fstate != fault_idle);
    next_st.alarm = (next_st.fstate != fault_idle);
    // retry only offered for real faults
    next_st.retry = (next_st.fstate == fault_real);

    // Read port answers one cycle after the request
    if (i_param_read) begin
      next_st.read_valid = 1'b1;
      unique case (i_read_select)
        `SEL_FAULT_INJECT: next_st.read_data = `NO_ACTION_VALUE;
        `SEL_LINK_PRESET: next_st.read_data = `NO_ACTION_VALUE;
        `SEL_MENU_PRESET: next_st.read_data = `NO_ACTION_VALUE;
        `SEL_EXT_DISPLAY: next_st.read_data = st.ext_display;
        `SEL_OP_MODE: next_st.read_data = st.op_mode;
        `SEL_LINK_SPEED: next_st.read_data = st.speed;
        `SEL_STOP_BITS: next_st.read_data = st.stop_bits;
        `SEL_PARITY: next_st.read_data = st.parity;
        `SEL_RETRY: next_st.read_data = st.retry_count;
        `SEL_CHECK_INT: next_st.read_data = st.check_int;
        `SEL_WAIT_TIME: next_st.read_data = st.wait_time;
        `SEL_LINE_END: next_st.read_data = st.line_end;
        `SEL_STARTUP: next_st.read_data = st.startup;
        `SEL_PROTOCOL: next_st.read_data = st.protocol;
        default: next_st.read_data = 16'h0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  // Drive reset clears the fault latch and reloads the parameters with their power-up values
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st.fstate <= fault_idle;
      st.fault_code <= 16'h0000;
      st.trip <= 1'b0;
      st.alarm <= 1'b0;
      st.retry <= 1'b0;
      st.read_data <= 16'h0000;
      st.read_valid <= 1'b0;
      st.menu_error <= 1'b0;
      st.preset_done <= 1'b0;
      st.nv_store <= 1'b0;
      st.nv_select <= 4'h0;
      st.nv_data <= 16'h0000;
      st.op_mode <= `INI_OP_MODE;
      st.speed <= `INI_LINK_SPEED;
      st.stop_bits <= `INI_STOP_BITS;
      st.parity <= `INI_PARITY;
      st.retry_count <= `INI_RETRY;
      st.check_int <= `INI_CHECK_INT;
      st.wait_time <= `INI_WAIT_TIME;
      st.line_end <= `INI_LINE_END;
      st.startup <= `INI_STARTUP;
      st.protocol <= `INI_PROTOCOL;
      st.ext_display <= `INI_EXT_DISPLAY;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------
  // Outputs, all from flip-flops
  // -------------------------------------------------------------
  assign o_read_data = st.read_data;
  assign o_read_valid = st.read_valid;
  assign o_trip = st.trip;
  assign o_alarm_output = st.alarm;
  assign o_retry_enable = st.retry;
  assign o_newest_fault = newest_shown;
  assign o_menu_error = st.menu_error;
  assign o_preset_done = st.preset_done;
  assign o_nv_store = st.nv_store;
  assign o_nv_select = st.nv_select;
  assign o_nv_data = st.nv_data;
  assign o_operation_mode_select = st.op_mode;
  assign o_panel_link_speed = st.speed;
  assign o_panel_link_stop_bits = st.stop_bits;
  assign o_panel_link_parity = st.parity;
  assign o_panel_link_retry_count = st.retry_count;
  assign o_panel_link_check_interval = st.check_int;
  assign o_panel_link_wait_time = st.wait_time;
  assign o_panel_link_line_ending = st.line_end;
  assign o_link_startup_mode = st.startup;
  assign o_protocol_select = st.protocol;
  assign o_extended_display_select = st.ext_display;
endmodule
`default_nettype wire

//--- testbench/fault_preset_assertions.sv
// Port checks for the fault injection and link preset block
`include "fault_preset_defines.svh"
`default_nettype none
module fault_preset_assertions (
  // Clock, reset and requests
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_param_write,
  input wire logic [3:0] i_param_select,
  input wire logic [15:0] i_param_data,
  input wire logic i_param_read,
  input wire logic [3:0] i_read_select,
  input wire logic i_real_fault,
  input wire logic i_panel_mode,
  // Watched outputs
  input wire logic [15:0] o_read_data,
  input wire logic o_read_valid,
  input wire logic o_trip,
  input wire logic o_alarm_output,
  input wire logic o_retry_enable,
  input wire logic [15:0] o_newest_fault,
  input wire logic o_menu_error,
  input wire logic o_preset_done,
  input wire logic o_nv_store,
  input wire logic [3:0] o_nv_select,
  input wire logic [15:0] o_nv_data,
  input wire logic [15:0] o_panel_link_stop_bits,
  input wire logic [15:0] o_panel_link_retry_count,
  input wire logic [15:0] o_extended_display_select
);
  // ------------------------------------------------------------
  // Shorthands
  // ------------------------------------------------------------
  logic inj;
  logic lnk;
  logic mnu;
  logic calm;
  logic idle;
  logic [1:0] real_hist;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Writes per setting; calm means nothing latched and no real fault pending
  assign inj = i_param_write && i_param_select == `SEL_FAULT_INJECT;
  assign lnk = i_param_write && i_param_select == `SEL_LINK_PRESET;
  assign mnu = i_param_write && i_param_select == `SEL_MENU_PRESET;
  // A real fault of the last two edges may still sit in the synchroniser
  always_ff @(posedge i_clock) begin
    real_hist <= {real_hist[0], i_real_fault};
  end
  assign calm = !o_trip && !i_real_fault && !real_hist;
  assign idle = calm && o_extended_display_select == `EXT_DISPLAY_FULL;

  AST_INJECT_TRIPS: assert property (
    inj && i_param_data == 16'h0010 && idle |=> o_trip && o_alarm_output)
    else $error("injection did not trip");
  AST_INJECT_SHOWN: assert property (
    inj && i_param_data == 16'h0010 && idle |=> !o_retry_enable ##1 o_newest_fault == 16'h0010)
    else $error("injected fault shown wrongly");
  AST_INJECT_REFUSED: assert property (
    inj && calm && (i_param_data inside {`NO_ACTION_VALUE, 16'h0013}
    || o_extended_display_select != `EXT_DISPLAY_FULL) |=> !o_trip)
    else $error("refused injection tripped");
  AST_TRIP_LATCHED: assert property (
    o_trip |=> o_trip && o_alarm_output)
    else $error("trip dropped without reset");
  AST_HISTORY_FROZEN: assert property (
    o_trip && $past(o_trip) && !o_retry_enable |=> $stable(o_newest_fault))
    else $error("newest fault moved while injected");
  AST_NO_NV_TRIGGER: assert property (
    i_param_write && i_param_select <= `SEL_MENU_PRESET |=> !o_nv_store)
    else $error("trigger write reached storage");
  AST_NV_PARAM: assert property (
    i_param_write && i_param_select inside {[`SEL_EXT_DISPLAY:`SEL_PROTOCOL]}
    |=> o_nv_store && o_nv_select == $past(i_param_select)
    && o_nv_data == $past(i_param_data))
    else $error("parameter write not stored");
  AST_READ_NO_ACTION: assert property (
    i_param_read && i_read_select <= `SEL_LINK_PRESET
    |=> o_read_valid && o_read_data == `NO_ACTION_VALUE)
    else $error("trigger read not 9999");
  AST_LINK_PRESET: assert property (
    lnk && i_param_data == `LINK_PRESET_CODE |=> o_preset_done
    && o_panel_link_stop_bits == `PRE_STOP_BITS && o_panel_link_retry_count == `PRE_RETRY)
    else $error("link preset not loaded");
  AST_LINK_IDLE: assert property (
    lnk && i_param_data == `NO_ACTION_VALUE |=> !o_preset_done)
    else $error("9999 ran a preset");
  AST_MENU_REFUSED: assert property (
    (!i_panel_mode) [*4] ##0 mnu |=> o_menu_error && !o_preset_done)
    else $error("menu preset not refused");
  AST_MENU_PRESET: assert property (
    i_panel_mode [*4] ##0 (mnu && i_param_data == `MENU_PRESET_CODE)
    |=> o_preset_done && !o_menu_error && o_panel_link_stop_bits == `PRE_STOP_BITS)
    else $error("menu preset not loaded");
endmodule
bind fault_preset_unit fault_preset_assertions fault_preset_assertions_i (.*);
`default_nettype wire

//--- testbench/panel_host_model.sv
// Operator panel model that resets the drive and writes or reads settings
`default_nettype none
module panel_host_model (
  // Clock and read answer
  input wire logic i_clock,
  input wire logic [15:0] i_read_data,
  input wire logic i_read_valid,
  // Requests
  output logic o_rst,
  output logic o_write,
  output logic o_read,
  output logic [3:0] o_select,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rst = 1'b1;
    o_write = 1'b0;
    o_read = 1'b0;
    o_select = 4'hf;
    o_data = 16'h0000;
  end
  // One-cycle write; lines scrambled after so stale values never look valid
  task automatic put_param(input logic [3:0] sel, input logic [15:0] data);
    @(negedge i_clock);
    o_write = 1'b1;
    o_select = sel;
    o_data = data;
    @(negedge i_clock);
    o_write = 1'b0;
    o_select = ~sel;
    o_data = ~data;
  endtask
  // One-cycle read; the answer is taken in the cycle it stands
  task automatic get_param(input logic [3:0] sel, output logic [15:0] d, output logic v);
    @(negedge i_clock);
    o_read = 1'b1;
    o_select = sel;
    @(negedge i_clock);
    o_read = 1'b0;
    o_select = ~sel;
    d = i_read_data;
    v = i_read_valid;
  endtask
  task automatic drive_reset();
    @(negedge i_clock);
    o_rst = 1'b1;
    repeat (20) @(negedge i_clock);
    o_rst = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the fault injection and link preset block
`include "fault_preset_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst, wr, rd, rd_valid, real_fault, panel_mode, trip, alarm, retry, menu_error, done;
  logic [3:0] sel;
  logic [15:0] data, rd_data, real_code, newest;
  logic [15:0] prm [11];
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  // Parameter tables in port order, last entry the display select
  logic [15:0] ini_exp [11] = '{`INI_OP_MODE, `INI_LINK_SPEED, `INI_STOP_BITS, `INI_PARITY,
    `INI_RETRY, `INI_CHECK_INT, `INI_WAIT_TIME, `INI_LINE_END, `INI_STARTUP, `INI_PROTOCOL,
    `INI_EXT_DISPLAY};
  logic [15:0] pre_exp [11] = '{`PRE_OP_MODE, `PRE_LINK_SPEED, `PRE_STOP_BITS, `PRE_PARITY,
    `PRE_RETRY, `PRE_CHECK_INT, `PRE_WAIT_TIME, `PRE_LINE_END, `PRE_STARTUP, `PRE_PROTOCOL,
    `INI_EXT_DISPLAY};
  logic [15:0] codes [28] = '{16'h0010, 16'h0011, 16'h0012, 16'h0020, 16'h0021, 16'h0022,
    16'h0030, 16'h0031, 16'h0040, 16'h0052, 16'h0060, 16'h0061, 16'h0070, 16'h0080, 16'h0081,
    16'h0090, 16'h0091, 16'h00b0, 16'h00b1, 16'h00b2, 16'h00c0, 16'h00c4, 16'h00c5, 16'h00c7,
    16'h00c9, 16'h00d0, 16'h00e6, 16'h00f5};
  logic [15:0] bad [4] = '{`NO_ACTION_VALUE, 16'h0013, 16'h00c1, 16'h0000};

  always #10 clock = ~clock;

  fault_preset_unit fault_preset_unit_i (
    .i_clock(clock), .i_rst(rst), .i_param_write(wr), .i_param_select(sel),
    .i_param_data(data), .i_param_read(rd), .i_read_select(sel), .o_read_data(rd_data),
    .o_read_valid(rd_valid), .i_real_fault(real_fault), .i_real_fault_code(real_code),
    .i_panel_mode(panel_mode), .o_trip(trip), .o_alarm_output(alarm), .o_retry_enable(retry),
    .o_newest_fault(newest), .o_menu_error(menu_error), .o_preset_done(done),
    .o_nv_store(), .o_nv_select(), .o_nv_data(), .o_operation_mode_select(prm[0]),
    .o_panel_link_speed(prm[1]), .o_panel_link_stop_bits(prm[2]),
    .o_panel_link_parity(prm[3]), .o_panel_link_retry_count(prm[4]),
    .o_panel_link_check_interval(prm[5]), .o_panel_link_wait_time(prm[6]),
    .o_panel_link_line_ending(prm[7]), .o_link_startup_mode(prm[8]),
    .o_protocol_select(prm[9]), .o_extended_display_select(prm[10]));

  panel_host_model host (.i_clock(clock), .i_read_data(rd_data), .i_read_valid(rd_valid),
    .o_rst(rst), .o_write(wr), .o_read(rd), .o_select(sel), .o_data(data));

  // ------------------------------------------------------------
  // Compare and closing tasks
  // ------------------------------------------------------------
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_params(input logic [15:0] exp [11]);
    foreach (exp[k]) check_word($sformatf("parameter %0d", k), exp[k], prm[k]);
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the run needs under 2000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset_state();
    logic [15:0] d;
    logic v;
    host.drive_reset();
    check_params(ini_exp);
    host.get_param(`SEL_FAULT_INJECT, d, v);
    check_word("injection read", `NO_ACTION_VALUE, d);
    check_flag("read valid", 1'b1, v);
    host.get_param(`SEL_LINK_PRESET, d, v);
    check_word("preset read", `NO_ACTION_VALUE, d);
  endtask
  task automatic test_refusals();
    host.put_param(`SEL_FAULT_INJECT, 16'h0010);
    check_flag("trip, display 9999", 1'b0, trip);
    host.put_param(`SEL_EXT_DISPLAY, `EXT_DISPLAY_FULL);
    foreach (bad[k]) begin
      host.put_param(`SEL_FAULT_INJECT, bad[k]);
      check_flag("trip, bad code", 1'b0, trip);
    end
  endtask
  // A real fault fills the history head that injections must not replace
  task automatic test_real_fault();
    real_code = 16'h0040;
    real_fault = 1'b1;
    repeat (6) @(negedge clock);
    check_flag("retry, real fault", 1'b1, retry);
    host.put_param(`SEL_FAULT_INJECT, 16'h0010);
    @(negedge clock);
    check_word("newest, inject over fault", 16'h0040, newest);
    check_flag("retry, inject over fault", 1'b1, retry);
    real_fault = 1'b0;
  endtask
  task automatic test_inject_hold();
    logic [15:0] d;
    logic v;
    host.drive_reset();
    host.put_param(`SEL_EXT_DISPLAY, `EXT_DISPLAY_FULL);
    host.put_param(`SEL_FAULT_INJECT, 16'h00b1);
    host.put_param(`SEL_FAULT_INJECT, 16'h0020);
    host.get_param(`SEL_FAULT_INJECT, d, v);
    check_word("injection read, tripped", `NO_ACTION_VALUE, d);
    check_word("newest, second inject", 16'h00b1, newest);
    real_code = 16'h0090;
    real_fault = 1'b1;
    repeat (6) @(negedge clock);
    check_word("newest, later fault", 16'h00b1, newest);
    check_flag("retry, later fault", 1'b0, retry);
    check_flag("trip held", 1'b1, trip);
    real_fault = 1'b0;
  endtask
  task automatic test_inject_codes();
    foreach (codes[k]) begin
      host.drive_reset();
      check_flag("trip after reset", 1'b0, trip);
      repeat (2) @(negedge clock);
      check_word("history restored", 16'h0040, newest);
      host.put_param(`SEL_EXT_DISPLAY, `EXT_DISPLAY_FULL);
      host.put_param(`SEL_FAULT_INJECT, codes[k]);
      check_flag("trip", 1'b1, trip);
      check_flag("alarm", 1'b1, alarm);
      check_flag("retry", 1'b0, retry);
      @(negedge clock);
      check_word("newest injected", codes[k], newest);
    end
  endtask
  task automatic test_link_preset();
    logic [15:0] d;
    logic v;
    host.drive_reset();
    host.put_param(`SEL_STOP_BITS, 16'h0005);
    host.put_param(`SEL_LINK_PRESET, `NO_ACTION_VALUE);
    check_flag("done, 9999", 1'b0, done);
    check_word("stop bits kept", 16'h0005, prm[2]);
    host.put_param(`SEL_LINK_PRESET, `LINK_PRESET_CODE);
    check_flag("done, preset", 1'b1, done);
    check_params(pre_exp);
    host.get_param(`SEL_STOP_BITS, d, v);
    check_word("stop bits read", `PRE_STOP_BITS, d);
  endtask
  task automatic test_menu_preset();
    host.put_param(`SEL_STOP_BITS, 16'h0005);
    host.put_param(`SEL_MENU_PRESET, `MENU_PRESET_CODE);
    check_flag("menu error", 1'b1, menu_error);
    check_word("stop bits, refused", 16'h0005, prm[2]);
    panel_mode = 1'b1;
    repeat (3) @(negedge clock);
    host.put_param(`SEL_MENU_PRESET, `MENU_PRESET_CODE);
    check_flag("done, menu", 1'b1, done);
    check_params(pre_exp);
    host.drive_reset();
  endtask

  initial begin
    real_fault = 1'b0;
    panel_mode = 1'b0;
    real_code = 16'h0000;
    test_reset_state();
    test_refusals();
    test_real_fault();
    test_inject_hold();
    test_inject_codes();
    test_link_preset();
    test_menu_preset();
    end_of_test();
  end
endmodule
`default_nettype wire
